// ### pcs_iso_map.svh
// Register offsets, field positions, reset values and code groups for the
// isolate and loopback control block. Assumes a 12-bit AXI4-Lite byte address.
`ifndef PCS_ISO_MAP_SVH
`define PCS_ISO_MAP_SVH

// ***********************************************
// Register map
// ***********************************************
`define CTRL_OFF 12'h000
`define STATUS_OFF 12'h004
`define CTRL_ISOLATE_BIT 0
`define CTRL_LOOPBACK_BIT 1
`define STAT_ISOLATE_BIT 0
`define STAT_LOOPBACK_BIT 1
`define STAT_MGMT_BIT 2
`define STAT_TBI_BIT 3

// ***********************************************
// Reset values and fixed outputs
// ***********************************************
`define ISOLATE_RESET 1'h1
`define LOOPBACK_RESET 1'h0
`define XCVR_LOOP_SEL 2'h0

// ***********************************************
// Code groups and bus answers
// ***********************************************
`define IDLE_COMMA_CODE 8'hbc
`define IDLE_DATA_CODE 8'h50
`define ERROR_CODE 8'hfe
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ### pcs_iso_pkg.sv
// Types shared by the isolate and loopback control block.
// Assumes pcs_iso_map.svh carries the register, reset, code group and response constants.
package pcs_iso_pkg;

	// Two halves of an idle ordered set
	typedef enum logic {
		IDLE_COMMA,
		IDLE_DATA
	} idle_phase_t;

endpackage : pcs_iso_pkg

// ### pair_buffer.sv
// Small valid/ready buffer, flip-flop storage indexed by pointers.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module pair_buffer #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [IW-1:0] wr_idx_r, wr_idx_nxt, rd_idx_r, rd_idx_nxt;
	logic [CW-1:0] count_r, count_nxt;
	logic push, pop;

	// Pointer step with wrap at the depth
	function automatic logic [IW-1:0] step(input logic [IW-1:0] idx);
		step = (idx == IW'(DEPTH - 1)) ? '0 : idx + 1'b1;
	endfunction : step

	// Honest full and empty flags
	assign in_ready = (count_r != CW'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_idx_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next pointers, count and storage
	always_comb begin
		mem_nxt = mem_r;
		wr_idx_nxt = wr_idx_r;
		rd_idx_nxt = rd_idx_r;
		count_nxt = count_r;
		if (push) begin
			mem_nxt[wr_idx_r] = in_data;
			wr_idx_nxt = step(wr_idx_r);
		end
		if (pop) begin
			rd_idx_nxt = step(rd_idx_r);
		end
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	// Register stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			count_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			wr_idx_r <= wr_idx_nxt;
			rd_idx_r <= rd_idx_nxt;
			count_r <= count_nxt;
			mem_r <= mem_nxt;
		end
	end

endmodule : pair_buffer

// ### pcs_isolate_loopback_control.sv
// Start-up isolation and loopback control between a GMII client and the line.
// Assumes one 125 MHz-class clock (aclk, modelled at 50 MHz), a synchronous
// active-low reset and an AXI4-Lite master for the control registers.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "pcs_iso_map.svh"

module pcs_isolate_loopback_control #(
	parameter bit MGMT_PRESENT = 1'b1,
	parameter bit TBI_VARIANT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic static_isolate,
	input wire logic static_loopback,
	input wire logic [7:0] gmii_txd,
	input wire logic gmii_tx_en,
	input wire logic gmii_tx_er,
	output logic [7:0] gmii_rxd,
	output logic gmii_rx_dv,
	output logic gmii_rx_er,
	input wire logic gmii_rx_ready,
	output logic [7:0] line_tx_code,
	output logic line_tx_is_k,
	input wire logic [7:0] line_rx_code,
	input wire logic line_rx_is_k,
	input wire logic line_rx_valid,
	output logic line_rx_ready,
	output logic serdes_wrap,
	output logic [1:0] xcvr_loopback_sel
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ***********************************************
	// Declarations
	// ***********************************************
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [11:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic w_strb0_r, w_strb0_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic ctrl_iso_r, ctrl_iso_nxt, ctrl_loop_r, ctrl_loop_nxt;
	logic wr_commit;
	logic st_q1_r, st_q2_r, st_q3_r, sl_q1_r, sl_q2_r, sl_q3_r;
	logic st_iso_r, st_iso_nxt, st_loop_r, st_loop_nxt;
	logic isolate_r, isolate_nxt, loop_r, loop_nxt, int_loop;
	pcs_iso_pkg::idle_phase_t phase_r, phase_nxt;
	logic [7:0] tx_code_r, tx_code_nxt, line_code_r, line_code_nxt;
	logic tx_k_r, tx_k_nxt, line_k_r, line_k_nxt, wrap_r, wrap_nxt;
	logic [9:0] buf_in_data, buf_out_data;
	logic buf_in_valid, buf_in_ready, buf_out_valid;

	// Code group to {rx_dv, rx_er, rxd}; K codes other than the error code carry nothing
	function automatic logic [9:0] decode(input logic [7:0] code, input logic is_k);
		if (!is_k) begin
			decode = {2'h2, code};
		end else if (code == `ERROR_CODE) begin
			decode = {2'h1, 8'h00};
		end else begin
			decode = 10'h000;
		end
	endfunction : decode

	// ***********************************************
	// AXI4-Lite write channel
	// ***********************************************
	// One write at a time: address and data parked until both are in
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign wr_commit = aw_have_r && w_have_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_strb0_nxt = w_strb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		ctrl_iso_nxt = ctrl_iso_r;
		ctrl_loop_nxt = ctrl_loop_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb0_nxt = s_axi_wstrb[0];
		end
		if (wr_commit) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = `RESP_DECERR;
			if (aw_addr_r[11:2] == `CTRL_OFF >> 2) begin
				bresp_nxt = `RESP_OKAY;
				if (w_strb0_r) begin
					ctrl_iso_nxt = w_data_r[`CTRL_ISOLATE_BIT];
					ctrl_loop_nxt = w_data_r[`CTRL_LOOPBACK_BIT];
				end
			end else if (aw_addr_r[11:2] == `STATUS_OFF >> 2) begin
				bresp_nxt = `RESP_OKAY;
			end
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_have_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			ctrl_iso_r <= `ISOLATE_RESET;
			ctrl_loop_r <= `LOOPBACK_RESET;
		end else begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_strb0_r <= w_strb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			ctrl_iso_r <= ctrl_iso_nxt;
			ctrl_loop_r <= ctrl_loop_nxt;
		end
	end

	// ***********************************************
	// AXI4-Lite read channel
	// ***********************************************
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Status shows live state, not the written request
	always_comb begin
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (s_axi_araddr[11:2] == `CTRL_OFF >> 2) begin
				rdata_nxt[`CTRL_ISOLATE_BIT] = ctrl_iso_r;
				rdata_nxt[`CTRL_LOOPBACK_BIT] = ctrl_loop_r;
			end else if (s_axi_araddr[11:2] == `STATUS_OFF >> 2) begin
				rdata_nxt[`STAT_ISOLATE_BIT] = isolate_r;
				rdata_nxt[`STAT_LOOPBACK_BIT] = loop_r;
				rdata_nxt[`STAT_MGMT_BIT] = MGMT_PRESENT;
				rdata_nxt[`STAT_TBI_BIT] = TBI_VARIANT;
			end else begin
				rresp_nxt = `RESP_DECERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= `RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ***********************************************
	// Static configuration and mode selection
	// ***********************************************
	// Static pins pass three stages; a change counts once stages two and three agree
	always_comb begin
		st_iso_nxt = (st_q2_r == st_q3_r) ? st_q3_r : st_iso_r;
		st_loop_nxt = (sl_q2_r == sl_q3_r) ? sl_q3_r : st_loop_r;
		// Loopback source follows the build option
		isolate_nxt = MGMT_PRESENT ? ctrl_iso_r : st_iso_r;
		loop_nxt = MGMT_PRESENT ? ctrl_loop_r : st_loop_r;
	end

	// Isolated from reset; pin stages reset to the register reset values so no release glitch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q1_r <= 1'b1;
			st_q2_r <= 1'b1;
			st_q3_r <= 1'b1;
			sl_q1_r <= 1'b0;
			sl_q2_r <= 1'b0;
			sl_q3_r <= 1'b0;
			st_iso_r <= `ISOLATE_RESET;
			st_loop_r <= `LOOPBACK_RESET;
			isolate_r <= `ISOLATE_RESET;
			loop_r <= `LOOPBACK_RESET;
		end else begin
			st_q1_r <= static_isolate;
			st_q2_r <= st_q1_r;
			st_q3_r <= st_q2_r;
			sl_q1_r <= static_loopback;
			sl_q2_r <= sl_q1_r;
			sl_q3_r <= sl_q2_r;
			st_iso_r <= st_iso_nxt;
			st_loop_r <= st_loop_nxt;
			isolate_r <= isolate_nxt;
			loop_r <= loop_nxt;
		end
	end

	// Reset release leaves the block isolated
	iso_after_reset_a: assert property ($past(!aresetn) |-> isolate_r)
		else $error("isolate not set after reset");

	// Register write reaches the loopback state two cycles on
	loop_ctrl_write_a: assert property (MGMT_PRESENT && wr_commit && w_strb0_r
		&& aw_addr_r == `CTRL_OFF |-> ##2 loop_r == $past(w_data_r[`CTRL_LOOPBACK_BIT], 2))
		else $error("loopback register write not applied");

	// ***********************************************
	// Transmit code groups and line outputs
	// ***********************************************
	assign int_loop = loop_r && !TBI_VARIANT;

	// Transmit input ignored while isolated; line idles in internal loopback
	always_comb begin
		phase_nxt = (phase_r == pcs_iso_pkg::IDLE_COMMA) ? pcs_iso_pkg::IDLE_DATA : pcs_iso_pkg::IDLE_COMMA;
		tx_k_nxt = (phase_r == pcs_iso_pkg::IDLE_COMMA);
		tx_code_nxt = tx_k_nxt ? `IDLE_COMMA_CODE : `IDLE_DATA_CODE;
		if (!isolate_r && gmii_tx_en) begin
			tx_k_nxt = gmii_tx_er;
			tx_code_nxt = gmii_tx_er ? `ERROR_CODE : gmii_txd;
		end
		line_k_nxt = tx_k_nxt;
		line_code_nxt = tx_code_nxt;
		if (int_loop) begin
			line_k_nxt = (phase_r == pcs_iso_pkg::IDLE_COMMA);
			line_code_nxt = line_k_nxt ? `IDLE_COMMA_CODE : `IDLE_DATA_CODE;
		end
		// Ten-bit variant loops only in the external SerDes
		wrap_nxt = loop_r && TBI_VARIANT;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= pcs_iso_pkg::IDLE_COMMA;
			tx_code_r <= `IDLE_COMMA_CODE;
			tx_k_r <= 1'b1;
			line_code_r <= `IDLE_COMMA_CODE;
			line_k_r <= 1'b1;
			wrap_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			tx_code_r <= tx_code_nxt;
			tx_k_r <= tx_k_nxt;
			line_code_r <= line_code_nxt;
			line_k_r <= line_k_nxt;
			wrap_r <= wrap_nxt;
		end
	end

	assign line_tx_code = line_code_r;
	assign line_tx_is_k = line_k_r;
	assign serdes_wrap = wrap_r;
	// Transceiver loopback select held at zero
	assign xcvr_loopback_sel = `XCVR_LOOP_SEL;

	sequence loop_held_s;
		int_loop[*2];
	endsequence
	sequence line_idle_s;
		(line_tx_is_k && line_tx_code == `IDLE_COMMA_CODE) || (!line_tx_is_k && line_tx_code == `IDLE_DATA_CODE);
	endsequence

	// Only idles reach the line while looping internally
	line_idle_loop_a: assert property (loop_held_s |-> line_idle_s)
		else $error("non-idle code on line during loopback");

	// Wrap request tracks loopback in the ten-bit variant
	wrap_follows_a: assert property (loop_r != $past(loop_r) |=> serdes_wrap == (TBI_VARIANT && $past(loop_r)))
		else $error("wrap request does not follow loopback");

	// Loopback select never leaves zero, even in loopback
	xcvr_sel_zero_a: assert property (loop_r |-> ##1 xcvr_loopback_sel == 2'h0)
		else $error("transceiver loopback select not zero");

	// A frame start while isolated yields idles, not data
	tx_iso_ignore_a: assert property (isolate_r && gmii_tx_en |=> tx_code_r == (tx_k_r ? `IDLE_COMMA_CODE : `IDLE_DATA_CODE))
		else $error("transmit data passed while isolated");

	// ***********************************************
	// Receive path and buffering
	// ***********************************************
	// Internal loopback taps transmit codes just before the line
	assign buf_in_data = int_loop ? decode(tx_code_r, tx_k_r) : decode(line_rx_code, line_rx_is_k);
	assign buf_in_valid = int_loop || line_rx_valid;
	// Line is discarded during internal loopback, so never stall it then
	assign line_rx_ready = int_loop || buf_in_ready;

	// Loopback words are dropped if the client stalls with the buffer full
	pair_buffer #(
		.WIDTH(10),
		.DEPTH(2)
	) u_rx_buffer (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(buf_out_valid),
		.out_ready(gmii_rx_ready || isolate_r),
		.out_data(buf_out_data)
	);

	// Receive outputs held quiet while isolated; buffer drains meanwhile
	assign gmii_rx_dv = buf_out_valid && !isolate_r && buf_out_data[9];
	assign gmii_rx_er = buf_out_valid && !isolate_r && buf_out_data[8];
	assign gmii_rxd = (buf_out_valid && !isolate_r) ? buf_out_data[7:0] : 8'h00;

	// Transmitted byte appears at the buffer input one cycle later
	loop_path_a: assert property (int_loop && $past(int_loop) && $past(gmii_tx_en && !gmii_tx_er && !isolate_r)
		|-> buf_in_valid && buf_in_data == {2'h2, $past(gmii_txd)})
		else $error("loopback byte not on receive path");

	rx_iso_quiet_a: assert property (isolate_r |-> !gmii_rx_dv && !gmii_rx_er && gmii_rxd == 8'h00)
		else $error("receive active while isolated");

endmodule : pcs_isolate_loopback_control

// ### line_partner.sv
// Line-side partner model: a SerDes or transceiver feeding receive code groups.
// Assumes the bench calls send() right after a rising edge of aclk.
`timescale 1ns/1ps

module line_partner (
	input wire logic aclk,
	input wire logic line_rx_ready,
	output logic [7:0] line_rx_code,
	output logic line_rx_is_k,
	output logic line_rx_valid
);
	// ***********************************************
	// Code group source
	// ***********************************************

	// Quiet line at time zero
	initial begin
		line_rx_valid = 1'b0;
		line_rx_code = 8'h00;
		line_rx_is_k = 1'b0;
	end

	// Offer one code group, optionally late, and hold it until taken or 100 edges pass
	task automatic send(input logic [7:0] c, input logic k, input int gap);
		int n;
		repeat (gap) @(posedge aclk);
		line_rx_code <= c;
		line_rx_is_k <= k;
		line_rx_valid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (line_rx_ready) break;
		end
		// Stale value inverted so a late sample cannot pass by luck
		line_rx_valid <= 1'b0;
		line_rx_code <= ~c;
		line_rx_is_k <= ~k;
		// Let one edge pass so a following send never drives twice at once
		@(posedge aclk);
	endtask : send
endmodule : line_partner

// ### tb.sv
// Self-checking bench for the isolate and loopback control block.
// Assumes pcs_iso_map.svh and a line_partner model on the line receive side.
`timescale 1ns/1ps
`include "pcs_iso_map.svh"

module tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, static_isolate, static_loopback;
	logic gmii_tx_en, gmii_tx_er, gmii_rx_dv, gmii_rx_er, gmii_rx_ready, line_tx_is_k, line_rx_is_k;
	logic line_rx_valid, line_rx_ready, serdes_wrap, wrap2, dv2;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, xcvr_loopback_sel, sel2, r;
	logic [7:0] gmii_txd, gmii_rxd, line_tx_code, line_rx_code;
	logic [8:0] prv;
	int err_count, n_checks;

	// ***********************************************
	// Instances
	// ***********************************************
	pcs_isolate_loopback_control pcs_isolate_loopback_control_inst (.*);
	// Ten-bit build, static pins; shares inputs, own outputs
	pcs_isolate_loopback_control #(.MGMT_PRESENT(1'b0), .TBI_VARIANT(1'b1)) tbi_pcs_isolate_loopback_control_inst (
		.*, .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(),
		.s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .gmii_rxd(), .gmii_rx_dv(dv2), .gmii_rx_er(),
		.line_tx_code(), .line_tx_is_k(), .line_rx_ready(), .serdes_wrap(wrap2), .xcvr_loopback_sel(sel2));
	line_partner line_partner_inst (.aclk, .line_rx_ready, .line_rx_code, .line_rx_is_k, .line_rx_valid);

	// Free-running 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ***********************************************
	// Shared tasks
	// ***********************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	task automatic give_up(input string msg);
		err_count++;
		$display("unexpected at %0t: no answer on %s", $time, msg);
		end_sim();
	endtask : give_up

	// Write with both channels offered together; waits only as long as the bound
	task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 50) give_up("write");
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				v = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 50) give_up("read");
	endtask : axi_read

	// Line transmit must be an idle half, alternating each cycle
	task automatic idle_check(input bit first);
		logic [8:0] cur;
		cur = {line_tx_is_k, line_tx_code};
		check(cur === {1'b1, `IDLE_COMMA_CODE} || cur === {1'b0, `IDLE_DATA_CODE}, 1, "idle group");
		if (!first) check(cur !== prv, 1, "idle alternation");
		prv = cur;
	endtask : idle_check

	// ***********************************************
	// Scenarios
	// ***********************************************
	task automatic t_reset;
		axi_read(`CTRL_OFF, d, r);
		check(d, 32'h0000_0001, "ctrl reset");
		axi_read(`STATUS_OFF, d, r);
		check(d, 32'h0000_0005, "status reset");
		check(xcvr_loopback_sel, `XCVR_LOOP_SEL, "loop select");
		check(serdes_wrap, 0, "wrap at reset");
		$display("test reset done");
	endtask : t_reset

	// While isolated, transmit is ignored and a line word never reaches the client
	task automatic t_isolated;
		fork line_partner_inst.send(8'h12, 1'b0, 0); join_none
		@(posedge aclk);
		gmii_tx_en <= 1'b1;
		gmii_txd <= 8'h55;
		for (int i = 0; i < 8; i++) begin
			@(posedge aclk);
			idle_check(i == 0);
			check(gmii_rx_dv, 0, "rx while isolated");
		end
		gmii_tx_en <= 1'b0;
		$display("test isolated done");
	endtask : t_isolated

	task automatic t_release;
		axi_write(`CTRL_OFF, 32'h0000_0000, r);
		check(r, `RESP_OKAY, "release resp");
		axi_read(`STATUS_OFF, d, r);
		check(d, 32'h0000_0004, "status released");
		// Plain data, then an error-marked byte
		for (int i = 0; i < 2; i++) begin
			@(posedge aclk);
			gmii_tx_en <= 1'b1;
			gmii_tx_er <= i[0];
			gmii_txd <= 8'h55;
			@(posedge aclk);
			gmii_tx_en <= 1'b0;
			gmii_tx_er <= 1'b0;
			@(posedge aclk);
			check({line_tx_is_k, line_tx_code}, i ? {1'b1, `ERROR_CODE} : 9'h055, "tx code");
		end
		$display("test release done");
	endtask : t_release

	// Client stalls: two words fill the buffer, the third waits, then all drain in order
	task automatic t_buffer;
		logic [7:0] q[$];
		gmii_rx_ready <= 1'b0;
		fork
			begin
				line_partner_inst.send(8'h12, 1'b0, 0);
				line_partner_inst.send(8'h34, 1'b0, 0);
				line_partner_inst.send(8'h56, 1'b0, 2);
			end
		join_none
		repeat (10) @(posedge aclk);
		check(line_rx_ready, 0, "buffer full");
		check({gmii_rx_dv, gmii_rxd}, 9'h112, "head word");
		check(dv2, 0, "static isolate holds");
		gmii_rx_ready <= 1'b1;
		for (int i = 0; i < 20 && q.size() < 3; i++) begin
			@(posedge aclk);
			if (gmii_rx_dv) q.push_back(gmii_rxd);
		end
		if (q.size() < 3) give_up("drain");
		check({q[0], q[1], q[2]}, 24'h12_3456, "drain order");
		check(line_rx_valid, 0, "line sender finished");
		$display("test buffer done");
	endtask : t_buffer

	task automatic t_loopback;
		bit seen, seen_er;
		axi_write(`CTRL_OFF, 32'h0000_0002, r);
		axi_read(`STATUS_OFF, d, r);
		check(d, 32'h0000_0006, "status loopback");
		check(serdes_wrap, 0, "no wrap with transceiver");
		@(posedge aclk);
		gmii_tx_en <= 1'b1;
		gmii_txd <= 8'ha5;
		@(posedge aclk);
		gmii_tx_er <= 1'b1;
		@(posedge aclk);
		gmii_tx_en <= 1'b0;
		gmii_tx_er <= 1'b0;
		seen = 0;
		seen_er = 0;
		for (int i = 0; i < 10; i++) begin
			@(posedge aclk);
			idle_check(i == 0);
			if (gmii_rx_dv === 1'b1 && gmii_rxd === 8'ha5) seen = 1;
			if (gmii_rx_er === 1'b1) seen_er = 1;
		end
		check(seen, 1, "internal loopback");
		check(seen_er, 1, "looped error mark");
		check(line_rx_ready, 1, "line ignored");
		$display("test loopback done");
	endtask : t_loopback

	task automatic t_static;
		int n;
		static_isolate <= 1'b0;
		static_loopback <= 1'b1;
		for (n = 0; n < 10 && wrap2 !== 1'b1; n++) @(posedge aclk);
		check(wrap2, 1, "wrap raised");
		check(sel2, `XCVR_LOOP_SEL, "select fixed");
		static_loopback <= 1'b0;
		for (n = 0; n < 10 && wrap2 !== 1'b0; n++) @(posedge aclk);
		check(wrap2, 0, "wrap dropped");
		$display("test static done");
	endtask : t_static

	task automatic t_unmapped;
		axi_read(12'h008, d, r);
		check(r, `RESP_DECERR, "unmapped read resp");
		check(d, 32'h0000_0000, "unmapped read data");
		axi_write(12'h008, 32'h0000_0003, r);
		check(r, `RESP_DECERR, "unmapped write");
		axi_read(`CTRL_OFF, d, r);
		check(d, 32'h0000_0002, "ctrl untouched");
		$display("test unmapped done");
	endtask : t_unmapped

	// ***********************************************
	// Main sequence
	// ***********************************************
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'hf;
		{gmii_tx_en, gmii_tx_er, gmii_txd, static_loopback} = '0;
		static_isolate = 1'b1;
		gmii_rx_ready = 1'b1;
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_isolated();
		t_release();
		t_buffer();
		t_loopback();
		t_static();
		t_unmapped();
		end_sim();
	end
endmodule : tb
